// *** rcs_override_model.sv ***
// override circuitry model driving the data pins during reset
`timescale 1ns/1ps
module rcs_override_model (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_output_in, // reset output, high = asserted
  input wire logic [31:0] value_in, // override pattern
  output logic [31:0] data_pins_out // data bus seen by the device
);
  logic [31:0] pins_r = 32'h0;
  assign data_pins_out = pins_r;
  always @(posedge sys_clk_in) begin
    if (reset_output_in) begin
      pins_r <= value_in & ~(value_in[18] ? 32'h1000_0000 : 32'h0);
    end else begin
      pins_r <= ~pins_r; // released, no pull: keeps changing
    end
  end
endmodule : rcs_override_model

// *** rcs_pkg.sv ***
// shared constants and types for the reset configuration sampler
package rcs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  // system clock period in ns
  localparam int CLK_PERIOD_NS = 5;
  // output clock cycles the data pins stay inputs after reset out negates
  localparam int OE_HOLD_OUT_CLKS = 1;
  // width of the release hold counter
  localparam int CNT_W = 16;

  // ****************************************
  // data pin positions sampled during reset
  // ****************************************
  localparam int DATA_W = 32;
  localparam int POS_EMUL_N = 26;   // low selects emulation mode
  localparam int POS_BOOT_EXT = 18; // high selects external boot
  localparam int POS_BOOT_W32 = 19; // high selects 32-bit external port
  localparam int POS_PAD_FULL = 21;
  localparam int POS_LOOP_REF = 22;
  localparam int POS_LOOP_RATIO = 23;
  localparam int POS_FLASH_EN = 28;

  // ****************************************
  // default configuration, used without override
  // ****************************************
  localparam logic DEF_EMUL_N = 1'h1;    // not emulation
  localparam logic DEF_BOOT_EXT = 1'h0;  // internal boot
  localparam logic DEF_BOOT_W32 = 1'h1;
  localparam logic DEF_PAD_FULL = 1'h0;  // default strength
  localparam logic DEF_LOOP_RATIO = 1'h1;
  localparam logic DEF_LOOP_REF = 1'h1;
  localparam logic DEF_FLASH_EN = 1'h1;

  // ****************************************
  // types
  // ****************************************
  // decoded configuration bits
  typedef struct packed {
    logic boot_enable;      // chip_select_enable_bit of boot_select_control
    logic boot_width32;     // port_width_bit of boot_select_control, 1 = 32-bit
    logic secondary_enable; // chip_select_enable_bit of secondary_select_control
    logic pad_full;         // pad strength bit of chip_config_register
    logic loop_active;      // loop_active_bit of synth_status_register
    logic loop_ratio;       // loop_ratio_bit
    logic loop_reference;   // loop_reference_bit
    logic flash_enable;     // internal flash enable
    logic emulation;        // emulation mode seen in reset
  } rcs_cfg_t;

  // software write strobes and data for the writable bits
  typedef struct packed {
    logic boot_enable_we;
    logic boot_enable;
    logic boot_width_we;
    logic boot_width32;
    logic secondary_enable_we;
    logic secondary_enable;
    logic pad_we;
    logic pad_full;
  } rcs_sw_wr_t;

  // sequencing phases
  typedef enum logic [1:0] {
    PH_CONFIG,
    PH_RELEASE,
    PH_RUN
  } rcs_phase_t;

  // complete module state
  typedef struct packed {
    rcs_phase_t phase;
    logic [CNT_W-1:0] hold_cnt;
    logic pin_oe;
    logic cfg_valid;
    rcs_cfg_t cfg;
  } rcs_state_t;

  // value of the configuration after chip reset
  localparam rcs_cfg_t RST_CFG = '{
    boot_enable: 1'h0,
    boot_width32: 1'h1,
    secondary_enable: 1'h0,
    pad_full: 1'h0,
    loop_active: 1'h0,
    loop_ratio: 1'h0,
    loop_reference: 1'h0,
    flash_enable: 1'h1,
    emulation: 1'h0
  };

endpackage : rcs_pkg

// *** rcs_reset_config_sampler.sv ***
// reset configuration sampler: decodes override pins into boot, pad, clock and flash settings
//
// Notes on behaviour
// - boot disabled: enable clear, width 32-bit
// - 16-bit boot: enable set, width clear
// - 32-bit boot: enable and width set
// - secondary enable only emulation with internal boot
// - reset values kept, software may overwrite
// - boot pin low: internal boot, width ignored
// - boot high, width low: external 16-bit
// - both high: external 32-bit boot
// - pad strength taken from its data pin
// - software may rewrite pad strength later
// - clock mode read-only, writes after reset ignored
// - synth supply low: external clock, loop off
// - supply high: ratio and reference pins decide
// - flash enabled when its pin is high
// - overrides only while override pin asserted
// - reset sets every register to startup value
// - block never raises an interrupt
// - pins stay inputs one output clock after
`timescale 1ns/1ps
module rcs_reset_config_sampler #(
  parameter int OUT_CLK_DIV = 2 // system clocks per output clock cycle
) (
  input wire logic sys_clk_in,                         // system clock, 200 MHz
  input wire logic reset_in,                           // chip reset, async, active high
  input wire logic reset_output_in,                    // reset output pin asserted, high
  input wire logic [rcs_pkg::DATA_W-1:0] data_pins_in, // data bus pins as inputs
  input wire logic config_override_pin_n_in,           // override pin, active low
  input wire logic synth_supply_pin_in,                // synthesizer supply level
  input wire rcs_pkg::rcs_sw_wr_t sw_wr_in,            // software writes to writable bits
  output rcs_pkg::rcs_cfg_t cfg_out,                   // current configuration bits
  output logic [2:0] synth_status_out,                 // active, ratio, reference
  output logic cfg_valid_out,                          // configuration latched
  output logic data_pin_oe_out,                        // data pins may turn into outputs
  output logic irq_out                                 // interrupt request, always low
);

  // ****************************************
  // derived counts
  // ****************************************
  // system clocks the pins stay inputs after reset out negates
  localparam logic [rcs_pkg::CNT_W-1:0] HOLD_CYCLES =
    rcs_pkg::CNT_W'(rcs_pkg::OE_HOLD_OUT_CLKS * OUT_CLK_DIV);
  localparam logic [rcs_pkg::CNT_W-1:0] HOLD_LOAD = HOLD_CYCLES - 16'h0001;

  // ****************************************
  // signals
  // ****************************************
  localparam int SYNC_W = rcs_pkg::DATA_W + 2;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic [rcs_pkg::DATA_W-1:0] data_sync;
  logic override_n_sync;
  logic supply_sync;
  rcs_pkg::rcs_cfg_t sampled_cfg;
  rcs_pkg::rcs_state_t state_r;
  rcs_pkg::rcs_state_t state_nxt;

  // ****************************************
  // decode of the reset time pin levels
  // ****************************************
  function automatic rcs_pkg::rcs_cfg_t decode_cfg(
    input logic override_n,
    input logic supply,
    input logic [rcs_pkg::DATA_W-1:0] data
  );
    rcs_pkg::rcs_cfg_t c;
    logic emul_n;
    logic boot_ext;
    logic boot_w32;
    logic pad_full;
    logic ratio;
    logic refsel;
    logic flash;
    c = rcs_pkg::RST_CFG;
    // override used only with pin asserted
    if (!override_n) begin
      emul_n = data[rcs_pkg::POS_EMUL_N];
      boot_ext = data[rcs_pkg::POS_BOOT_EXT];
      boot_w32 = data[rcs_pkg::POS_BOOT_W32];
      pad_full = data[rcs_pkg::POS_PAD_FULL];
      ratio = data[rcs_pkg::POS_LOOP_RATIO];
      refsel = data[rcs_pkg::POS_LOOP_REF];
      flash = data[rcs_pkg::POS_FLASH_EN];
    end else begin
      emul_n = rcs_pkg::DEF_EMUL_N;
      boot_ext = rcs_pkg::DEF_BOOT_EXT;
      boot_w32 = rcs_pkg::DEF_BOOT_W32;
      pad_full = rcs_pkg::DEF_PAD_FULL;
      ratio = rcs_pkg::DEF_LOOP_RATIO;
      refsel = rcs_pkg::DEF_LOOP_REF;
      flash = rcs_pkg::DEF_FLASH_EN;
    end
    c.emulation = ~emul_n;
    if (!boot_ext) begin
      c.boot_enable = 1'h0;
      c.boot_width32 = 1'h1;
    end else if (!boot_w32) begin
      c.boot_enable = 1'h1;
      c.boot_width32 = 1'h0;
    end else begin
      c.boot_enable = 1'h1;
      c.boot_width32 = 1'h1;
    end
    // secondary select for emulated internal boot
    c.secondary_enable = c.emulation & ~boot_ext;
    c.pad_full = pad_full;
    if (!supply) begin
      c.loop_active = 1'h0;
      c.loop_ratio = 1'h0;
      c.loop_reference = 1'h0;
    end else begin
      // ratio then reference select the mode
      c.loop_active = 1'h1;
      c.loop_ratio = ratio;
      c.loop_reference = ratio & refsel;
    end
    c.flash_enable = flash;
    return c;
  endfunction : decode_cfg

  // ****************************************
  // pin synchronisation
  // ****************************************
  // pins come from the outside world and pass two flip-flops
  assign pins_raw = {config_override_pin_n_in, synth_supply_pin_in, data_pins_in};

  rcs_sync2 #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // split synchronised pins
  assign override_n_sync = pins_sync[SYNC_W-1];
  assign supply_sync = pins_sync[SYNC_W-2];
  assign data_sync = pins_sync[rcs_pkg::DATA_W-1:0];

  // continuous decode of the current pin levels
  assign sampled_cfg = decode_cfg(override_n_sync, supply_sync, data_sync);

  // ****************************************
  // next state
  // ****************************************
  // sequences reset sampling, pin release and software updates
  always_comb begin
    state_nxt = state_r;
    case (state_r.phase)
      rcs_pkg::PH_CONFIG: begin
        state_nxt.pin_oe = 1'h0;
        if (!reset_output_in) begin
          state_nxt.cfg = sampled_cfg;
          state_nxt.cfg_valid = 1'h1;
          state_nxt.hold_cnt = HOLD_LOAD;
          state_nxt.phase = rcs_pkg::PH_RELEASE;
        end
      end
      rcs_pkg::PH_RELEASE: begin
        if (reset_output_in) begin
          state_nxt.phase = rcs_pkg::PH_CONFIG;
          state_nxt.cfg_valid = 1'h0;
        end else if (state_r.hold_cnt == '0) begin
          // outputs allowed after one output clock
          state_nxt.pin_oe = 1'h1;
          state_nxt.phase = rcs_pkg::PH_RUN;
        end else begin
          state_nxt.hold_cnt = state_r.hold_cnt - 16'h0001;
        end
      end
      rcs_pkg::PH_RUN: begin
        if (reset_output_in) begin
          state_nxt.phase = rcs_pkg::PH_CONFIG;
          state_nxt.pin_oe = 1'h0;
          state_nxt.cfg_valid = 1'h0;
        end
      end
      default: begin
        state_nxt.phase = rcs_pkg::PH_CONFIG;
        state_nxt.pin_oe = 1'h0;
      end
    endcase
    // software updates once the configuration has been latched
    if (state_r.cfg_valid && !reset_output_in) begin
      if (sw_wr_in.boot_enable_we) begin
        state_nxt.cfg.boot_enable = sw_wr_in.boot_enable;
      end
      if (sw_wr_in.boot_width_we) begin
        state_nxt.cfg.boot_width32 = sw_wr_in.boot_width32;
      end
      if (sw_wr_in.secondary_enable_we) begin
        state_nxt.cfg.secondary_enable = sw_wr_in.secondary_enable;
      end
      if (sw_wr_in.pad_we) begin
        state_nxt.cfg.pad_full = sw_wr_in.pad_full;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // every field to its startup value
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r.phase <= rcs_pkg::PH_CONFIG;
      state_r.hold_cnt <= '0;
      state_r.pin_oe <= 1'h0;
      state_r.cfg_valid <= 1'h0;
      state_r.cfg <= rcs_pkg::RST_CFG;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_out = state_r.cfg;
  // clock mode has no write path
  assign synth_status_out = {state_r.cfg.loop_active, state_r.cfg.loop_ratio,
                             state_r.cfg.loop_reference};
  assign cfg_valid_out = state_r.cfg_valid;
  assign data_pin_oe_out = state_r.pin_oe;
  assign irq_out = 1'h0;

endmodule : rcs_reset_config_sampler

// *** rcs_sampler_properties.sv ***
// concurrent checks on the reset configuration sampler ports
`timescale 1ns/1ps
module rcs_sampler_chk #(
  parameter int OUT_CLK_DIV = 2 // system clocks per output clock
) (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_in, // chip reset
  input wire logic reset_output_in, // reset output asserted
  input wire logic [rcs_pkg::DATA_W-1:0] data_pins_in, // data pins
  input wire logic config_override_pin_n_in, // override pin
  input wire rcs_pkg::rcs_sw_wr_t sw_wr_in, // software writes
  input wire rcs_pkg::rcs_cfg_t cfg_out, // configuration bits
  input wire logic [2:0] synth_status_out, // clock mode bits
  input wire logic cfg_valid_out, // configuration latched
  input wire logic data_pin_oe_out, // pins may drive
  input wire logic irq_out // interrupt request
);
  // one clock domain, reset disables every check
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  property p_irq; irq_out == 1'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq raised");
  property p_off; reset_output_in |=> !data_pin_oe_out && !cfg_valid_out; endproperty
  a_off: assert property (p_off) else $error("pins or valid not dropped");
  property p_oe;
    $rose(cfg_valid_out) && !reset_output_in ##1 !reset_output_in |=> data_pin_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("pins not released in time");
  // pins must stay inputs for the whole hold after the latch
  property p_oe_hold; $rose(data_pin_oe_out) |-> $past(cfg_valid_out, 2); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pins released too early");
  property p_latch; $fell(reset_output_in) |=> cfg_valid_out; endproperty
  a_latch: assert property (p_latch) else $error("no latch at reset exit");
  property p_stat;
    synth_status_out == {cfg_out.loop_active, cfg_out.loop_ratio, cfg_out.loop_reference};
  endproperty
  a_stat: assert property (p_stat) else $error("status differs from mode");
  property p_frozen; cfg_valid_out && $past(cfg_valid_out) |-> $stable(synth_status_out);
  endproperty
  a_frozen: assert property (p_frozen) else $error("clock mode changed");
  // pins reach the latch through two flops, so they sit three samples back
  property p_flash;
    $rose(cfg_valid_out) |-> cfg_out.flash_enable == ($past(config_override_pin_n_in, 3) ?
      rcs_pkg::DEF_FLASH_EN : $past(data_pins_in[rcs_pkg::POS_FLASH_EN], 3));
  endproperty
  a_flash: assert property (p_flash) else $error("flash enable wrong");
  property p_boot;
    $rose(cfg_valid_out) |->
      cfg_out.boot_enable == (!$past(config_override_pin_n_in, 3) &&
      $past(data_pins_in[rcs_pkg::POS_BOOT_EXT], 3));
  endproperty
  a_boot: assert property (p_boot) else $error("boot enable wrong");
  property p_pad;
    cfg_valid_out && !reset_output_in && sw_wr_in.pad_we |=>
      cfg_out.pad_full == $past(sw_wr_in.pad_full);
  endproperty
  a_pad: assert property (p_pad) else $error("pad write lost");
  c_ovr: cover property ($rose(cfg_valid_out) && !config_override_pin_n_in);
  c_pad: cover property (cfg_valid_out && sw_wr_in.pad_we);
  c_oe: cover property ($rose(data_pin_oe_out));
endmodule : rcs_sampler_chk

bind rcs_reset_config_sampler rcs_sampler_chk #(.OUT_CLK_DIV(OUT_CLK_DIV)) i_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reset_output_in(reset_output_in),
  .data_pins_in(data_pins_in), .config_override_pin_n_in(config_override_pin_n_in),
  .sw_wr_in(sw_wr_in), .cfg_out(cfg_out), .synth_status_out(synth_status_out),
  .cfg_valid_out(cfg_valid_out), .data_pin_oe_out(data_pin_oe_out), .irq_out(irq_out));

// *** rcs_sync2.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcs_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,             // system clock
  input wire logic reset_in,               // async reset, active high
  input wire logic [WIDTH-1:0] async_in,   // pins from outside the domain
  output logic [WIDTH-1:0] sync_out        // synchronised copy
);

  logic [WIDTH-1:0] meta_r;

  // ****************************************
  // two stage chain, first stage read only by the second
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : rcs_sync2

// *** tb_rcs_reset_config_sampler.sv ***
// self-checking testbench for the reset configuration sampler
`timescale 1ns/1ps
module tb_rcs_reset_config_sampler;
  logic sys_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic rst_out = 1'h1;
  logic ovr_n = 1'h1;
  logic supply = 1'h1;
  logic [31:0] val = 32'h0;
  logic [31:0] pins;
  rcs_pkg::rcs_sw_wr_t sw = '0;
  rcs_pkg::rcs_cfg_t cfg;
  rcs_pkg::rcs_cfg_t e;
  logic [2:0] stat;
  logic valid;
  logic oe;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] tv [6] = '{32'h1020_0000, 32'h0404_0000, 32'h048c_0000, 32'h04c8_0000,
    32'h008c_0000, 32'hffff_ffff};

  // 200 MHz clock
  initial forever #2.5 sys_clk_in = ~sys_clk_in;

  rcs_override_model i_rcs_override_model (.sys_clk_in(sys_clk_in),
    .reset_output_in(rst_out), .value_in(val), .data_pins_out(pins));
  rcs_reset_config_sampler #(.OUT_CLK_DIV(2)) i_rcs_reset_config_sampler (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reset_output_in(rst_out),
    .data_pins_in(pins), .config_override_pin_n_in(ovr_n), .synth_supply_pin_in(supply),
    .sw_wr_in(sw), .cfg_out(cfg), .synth_status_out(stat), .cfg_valid_out(valid),
    .data_pin_oe_out(oe), .irq_out(irq));

  // ****************************************
  // helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // expected settings from pins, supply and override level
  function automatic rcs_pkg::rcs_cfg_t decode(input logic o, input logic s,
    input logic [31:0] v);
    logic [31:0] d;
    rcs_pkg::rcs_cfg_t c;
    d = v;
    if (o) begin
      d = {3'h0, rcs_pkg::DEF_FLASH_EN, 1'h0, rcs_pkg::DEF_EMUL_N, 2'h0,
        rcs_pkg::DEF_LOOP_RATIO, rcs_pkg::DEF_LOOP_REF, rcs_pkg::DEF_PAD_FULL, 1'h0,
        rcs_pkg::DEF_BOOT_W32, rcs_pkg::DEF_BOOT_EXT, 18'h0};
    end
    c = {d[18], !d[18] | d[19], !d[26] & !d[18], d[21], s, s & d[23], s & d[23] & d[22],
      d[28], !d[26]};
    return c;
  endfunction : decode
  // one reset output period with the given pin pattern
  task automatic run_cfg(input logic o, input logic s, input logic [31:0] v);
    rst_out = 1'h1;
    tick(1);
    check("oe off", 9'h0, 9'({valid, oe}));
    ovr_n = o;
    supply = s;
    val = v;
    tick(5);
    rst_out = 1'h0;
    tick(1);
    e = decode(o, s, v);
    check("cfg", e, cfg);
    check("status", 9'({e.loop_active, e.loop_ratio, e.loop_reference}), 9'(stat));
    check("oe early", 9'h2, 9'({valid, oe}));
    tick(2);
    check("oe", 9'h1, 9'(oe));
  endtask : run_cfg

  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // tests
  // ****************************************
  initial begin
    tick(16);
    check("reset cfg", rcs_pkg::RST_CFG, cfg);
    reset_in = 1'h0;
    for (int i = 0; i < 6; i++) begin
      run_cfg(i == 5, i != 0, tv[i]);
    end
    sw = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
    tick(1);
    sw = '0;
    e = {4'hb, e[4:0]};
    check("sw write", e, cfg);
    rst_out = 1'h1;
    sw.pad_we = 1'h1;
    tick(1);
    sw = '0;
    tick(1);
    check("refused write", e, cfg);
    reset_in = 1'h1;
    tick(1);
    check("reset cfg", rcs_pkg::RST_CFG, cfg);
    check("reset outs", 9'h0, 9'({stat, valid, oe, irq}));
    reset_in = 1'h0;
    run_cfg(1'h0, 1'h1, tv[2]);
    check("irq", 9'h0, 9'(irq));
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    repeat (1000) @(posedge sys_clk_in);
    failures++;
    report_and_stop();
  end
endmodule : tb_rcs_reset_config_sampler
